// file: verilog/clock_source_field_pkg.sv
// Package: register map, field layout, reset values and timing counts of the oscillator control
package clock_source_field_pkg;
    // ========================================
    // Register map
    localparam logic [11:0] OSC_CTRL_ADDR = 12'hF86;
    localparam logic [11:0] OSC_STATUS_ADDR = 12'hF87;
    localparam logic [11:0] OSC_MASK_ADDR = 12'hF88;
    localparam logic [11:0] OSC_OPTION_ADDR = 12'hF89;
    // ========================================
    // Field layout of oscillator_control
    localparam int PREC_EN_BIT = 7;
    localparam int XTAL_EN_BIT = 6;
    localparam int WDOG_EN_BIT = 5;
    localparam int PFAIL_EN_BIT = 4;
    localparam int WFAIL_EN_BIT = 3;
    localparam int SEL_MSB = 2;
    localparam int SEL_LSB = 0;
    localparam logic [7:0] OSC_CTRL_RESET = 8'hA0;
    // ========================================
    // Unlock keys
    localparam logic [7:0] UNLOCK_KEY1 = 8'hE7;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h18;
    // ========================================
    // Clock source codes
    localparam logic [2:0] SRC_PREC_FAST = 3'h0;
    localparam logic [2:0] SRC_PREC_SLOW = 3'h1;
    localparam logic [2:0] SRC_CRYSTAL = 3'h2;
    localparam logic [2:0] SRC_WATCHDOG = 3'h3;
    localparam logic [2:0] SRC_EXT_PIN = 3'h4;
    // ========================================
    // Status bits
    localparam int ST_PFAIL_BIT = 0;
    localparam int ST_WFAIL_BIT = 1;
    localparam int ST_RECOV_BIT = 2;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    // ========================================
    // Timing
    localparam int WDOG_FAIL_CYCLES = 8004;
    localparam int XTAL_SETTLE_PREC_CYCLES = 5000;
    localparam int PREC_CLK_HZ = 20000000;
    localparam int SYS_CLK_HZ = 125000000;
    // Settle window expressed in system cycles, rounded up
    localparam int XTAL_SETTLE_SYS_CYCLES =
        (XTAL_SETTLE_PREC_CYCLES * (SYS_CLK_HZ / 1000) + (PREC_CLK_HZ / 1000) - 1)
        / (PREC_CLK_HZ / 1000);
endpackage : clock_source_field_pkg

// file: verilog/clock_source_field_wdog_mon.sv
// Watchdog oscillator liveness monitor
`timescale 1ns/1ps
module clock_source_field_wdog_mon #(
    parameter int FAIL_CYCLES = clock_source_field_pkg::WDOG_FAIL_CYCLES
) (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_n_i, // Sync reset, active low
    input wire logic enable_i, // Detector armed
    input wire logic wdog_clk_i, // Watchdog oscillator, asynchronous
    output logic fail_o // One-cycle failure pulse
);
    import clock_source_field_pkg::*;

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic [13:0] count_ff;
    logic edge_seen;

    // ========================================
    // Two-stage synchroniser; only the second stage feeds the edge detector
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= wdog_clk_i;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign edge_seen = sync2_ff & ~prev_ff;

    // Count system clocks between watchdog edges; restart after each failure
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i || !enable_i || edge_seen)
        begin
            count_ff <= 14'h0000;
            fail_o <= 1'b0;
        end
        else if (count_ff == 14'(FAIL_CYCLES - 1))
        begin
            count_ff <= 14'h0000;
            fail_o <= 1'b1; // [R16]
        end
        else
        begin
            count_ff <= count_ff + 14'h0001;
            fail_o <= 1'b0;
        end
    end

    // ========================================
    // Assertions
    a_fail_needs_silence: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fail_o |-> $past(count_ff) == 14'(FAIL_CYCLES - 1)) // [R16]
        else $error("watchdog failure flagged early");
endmodule : clock_source_field_wdog_mon

// file: verilog/clock_source_field_ctrl.sv
// Oscillator control: locked control register, source select and failure recovery
//
// Contract
// [R1] Unlock by writing E7 then 18; only then does an update land.
// [R2] The register relocks after the one write that follows an unlock.
// [R3] Software unlocks before each write; locked writes change nothing.
// [R4] Bit 7 enables the internal precision oscillator.
// [R5] Bit 6 enables the crystal and takes over both crystal pins.
// [R6] Bit 5 enables the watchdog oscillator.
// [R7] Bit 4 enables primary failure detection and automatic recovery.
// [R8] Bit 3 enables watchdog oscillator failure detection; the code arms it only while bit 5 is also set.
// [R9] Bits 2:0 pick fast, slow, crystal, watchdog or external pin.
// [R10] Crystal runs through reset unless the option bit disables it.
// [R11] Software waits 5000 precision cycles after enabling crystal before selecting it.
// [R12] Four crystal power modes chosen only by option bits.
// [R13] Clock filter off by default: system clock equals crystal input.
// [R14] Any other write sequence is ignored; keys may be separated by accesses.
// [R15] Primary failure with recovery raises event, switches to watchdog if enabled.
// [R16] Watchdog failure declared after 8004 system cycles without an edge.
// [R17] Reset value is A0.
// [R18] Reserved select codes leave the current source unchanged.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module clock_source_field_ctrl #(
    parameter int WDOG_FAIL_LIMIT = clock_source_field_pkg::WDOG_FAIL_CYCLES
) (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_n_i, // Sync reset, active low
    input wire logic [11:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, cycle after strobe
    input wire logic xtal_dis_opt_i, // Option: crystal off during reset
    input wire logic [1:0] xtal_mode_opt_i, // Option: crystal power mode
    input wire logic primary_fail_i, // Primary clock too slow, asynchronous
    input wire logic wdog_clk_i, // Watchdog oscillator, asynchronous
    output logic prec_osc_en_o, // Precision oscillator enable
    output logic prec_slow_o, // Precision oscillator slow mode
    output logic crystal_osc_en_o, // Crystal oscillator enable
    output logic crystal_pin_own_o, // Crystal owns crystal_pin_a/b
    output logic [1:0] crystal_mode_o, // Crystal power mode
    output logic crystal_filter_en_o, // Input clock filter enable
    output logic watchdog_osc_en_o, // Watchdog oscillator enable
    output logic [2:0] sysclk_source_select_o, // Active system clock source
    output logic primary_fail_nmi_o, // Nonmaskable primary failure pulse
    output logic watchdog_fail_nmi_o, // Nonmaskable watchdog failure pulse
    output logic irq_o // Level interrupt
);
    import clock_source_field_pkg::*;

    typedef enum logic [1:0] {LOCKED, KEY1_SEEN, OPEN} clock_source_field_lock_e;

    clock_source_field_lock_e lock_ff;
    logic [7:0] ctrl_ff;
    logic [2:0] status_ff;
    logic [2:0] mask_ff;
    logic [2:0] nxt_status;
    logic pf_sync1_ff;
    logic pf_sync2_ff;
    logic pf_prev_ff;
    logic xtal_opt_ff;
    logic recovered_ff;
    logic pf_event;
    logic wf_event;
    logic ctrl_wr;
    logic ctrl_update;

    // Select codes above the external pin are reserved
    function automatic logic sel_valid(input logic [2:0] sel);
        sel_valid = (sel <= SRC_EXT_PIN);
    endfunction : sel_valid

    assign ctrl_wr = wr_i && (addr_i == OSC_CTRL_ADDR);
    assign ctrl_update = ctrl_wr && (lock_ff == OPEN);

    // ========================================
    // Unlock sequencer; other addresses do not disturb it
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            lock_ff <= LOCKED;
        end
        else if (ctrl_wr)
        begin
            case (lock_ff)
                LOCKED: lock_ff <= (wdata_i == UNLOCK_KEY1) ? KEY1_SEEN : LOCKED; // [R1]
                KEY1_SEEN: lock_ff <= (wdata_i == UNLOCK_KEY2) ? OPEN : LOCKED; // [R1] [R14]
                OPEN: lock_ff <= LOCKED; // [R2]
                default: lock_ff <= LOCKED;
            endcase
        end
    end

    // ========================================
    // Control register; recovery forces the watchdog source
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_ff <= OSC_CTRL_RESET; // [R17]
        end
        else if (pf_event && ctrl_ff[WDOG_EN_BIT]
            && ctrl_ff[SEL_MSB:SEL_LSB] != SRC_WATCHDOG)
        begin
            ctrl_ff[SEL_MSB:SEL_LSB] <= SRC_WATCHDOG; // [R15]
        end
        else if (ctrl_update)
        begin
            // Locked writes never get here [R3]
            ctrl_ff[7:3] <= wdata_i[7:3];
            if (sel_valid(wdata_i[SEL_MSB:SEL_LSB]))
            begin
                ctrl_ff[SEL_MSB:SEL_LSB] <= wdata_i[SEL_MSB:SEL_LSB]; // [R9]
            end
            // Reserved codes keep the running source [R18]
        end
    end

    // Reset-phase flag: high through reset, cleared on the first clock after release; option straps are read live
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            xtal_opt_ff <= 1'b1;
        end
        else
        begin
            xtal_opt_ff <= 1'b0;
        end
    end

    // ========================================
    // Primary failure input synchroniser and rising-edge event
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            pf_sync1_ff <= 1'b0;
            pf_sync2_ff <= 1'b0;
            pf_prev_ff <= 1'b0;
        end
        else
        begin
            pf_sync1_ff <= primary_fail_i;
            pf_sync2_ff <= pf_sync1_ff;
            pf_prev_ff <= pf_sync2_ff;
        end
    end

    // Event gated only by the detection enable, also when the watchdog is the selected source
    assign pf_event = pf_sync2_ff && !pf_prev_ff && ctrl_ff[PFAIL_EN_BIT]; // [R7]

    clock_source_field_wdog_mon #(
        .FAIL_CYCLES(WDOG_FAIL_LIMIT)
    ) u_wdog_mon (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .enable_i(ctrl_ff[WFAIL_EN_BIT] && ctrl_ff[WDOG_EN_BIT]), // [R8]
        .wdog_clk_i(wdog_clk_i),
        .fail_o(wf_event) // [R16]
    );

    // Flag, one cycle later, a primary failure event seen with the watchdog oscillator enabled
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            recovered_ff <= 1'b0;
        end
        else
        begin
            recovered_ff <= pf_event && ctrl_ff[WDOG_EN_BIT];
        end
    end

    // ========================================
    // Sticky status, write one to clear; a new event beats the clear
    always_comb
    begin
        nxt_status = status_ff;
        if (wr_i && addr_i == OSC_STATUS_ADDR)
        begin
            nxt_status = status_ff & ~wdata_i[2:0];
        end
        if (pf_event)
        begin
            nxt_status[ST_PFAIL_BIT] = 1'b1;
        end
        if (wf_event)
        begin
            nxt_status[ST_WFAIL_BIT] = 1'b1;
        end
        if (recovered_ff)
        begin
            nxt_status[ST_RECOV_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            status_ff <= STATUS_RESET;
        end
        else
        begin
            status_ff <= nxt_status;
        end
    end

    // Mask register
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            mask_ff <= MASK_RESET;
        end
        else if (wr_i && addr_i == OSC_MASK_ADDR)
        begin
            mask_ff <= wdata_i[2:0];
        end
    end

    assign irq_o = |(status_ff & mask_ff);

    // ========================================
    // Read port, data the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (rd_i)
        begin
            case (addr_i)
                OSC_CTRL_ADDR: rdata_o <= ctrl_ff;
                OSC_STATUS_ADDR: rdata_o <= {5'h00, status_ff};
                OSC_MASK_ADDR: rdata_o <= {5'h00, mask_ff};
                OSC_OPTION_ADDR: rdata_o <= {5'h00, xtal_mode_opt_i, xtal_dis_opt_i};
                default: rdata_o <= 8'h00;
            endcase
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

    // ========================================
    // Oscillator outputs
    // The settle wait after a manual crystal enable is software's job [R11]
    assign prec_osc_en_o = ctrl_ff[PREC_EN_BIT]; // [R4]
    assign prec_slow_o = (ctrl_ff[SEL_MSB:SEL_LSB] == SRC_PREC_SLOW); // [R9]
    assign crystal_osc_en_o = ctrl_ff[XTAL_EN_BIT] || (xtal_opt_ff && !xtal_dis_opt_i); // [R5] [R10]
    assign crystal_pin_own_o = crystal_osc_en_o; // [R5]
    assign crystal_mode_o = xtal_mode_opt_i; // [R12]
    assign crystal_filter_en_o = 1'b0; // [R13]
    assign watchdog_osc_en_o = ctrl_ff[WDOG_EN_BIT]; // [R6]
    assign sysclk_source_select_o = ctrl_ff[SEL_MSB:SEL_LSB]; // [R9]
    assign primary_fail_nmi_o = pf_event; // [R15]
    assign watchdog_fail_nmi_o = wf_event;

    // ========================================
    // Assertions
    a_locked_write_ignored: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (ctrl_wr && lock_ff != OPEN && !pf_event) |=> $stable(ctrl_ff)) // [R3]
        else $error("locked write changed control register");

    // Checked only on the opening edge: the register may stay open over idle cycles
    a_unlock_order: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(lock_ff == OPEN) |-> $past(ctrl_wr) && $past(wdata_i) == UNLOCK_KEY2
            && $past(lock_ff) == KEY1_SEEN) // [R1]
        else $error("register opened without second key");

    a_relock_after_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ctrl_update |=> lock_ff == LOCKED) // [R2]
        else $error("register stayed open after update");

    a_no_reserved_src: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sysclk_source_select_o <= SRC_EXT_PIN) // [R18]
        else $error("reserved clock source selected");

    a_recovery_switch: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (pf_event && watchdog_osc_en_o) |=> sysclk_source_select_o == SRC_WATCHDOG) // [R15]
        else $error("no switch to watchdog on failure");

    // The pin must have been high two edges back, through the synchroniser
    a_pfail_gated: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        primary_fail_nmi_o |-> ctrl_ff[PFAIL_EN_BIT] && $past(primary_fail_i, 2)) // [R7]
        else $error("primary failure event while disabled");

    a_status_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        pf_event |=> status_ff[ST_PFAIL_BIT] ##1 status_ff[ST_PFAIL_BIT] || wr_i) // [R15]
        else $error("primary failure status lost");

    a_key_wrong_relocks: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (lock_ff == KEY1_SEEN && ctrl_wr && wdata_i != UNLOCK_KEY2) |=> lock_ff == LOCKED) // [R14]
        else $error("bad second key did not relock");

    a_reset_value: assert property (@(posedge clk_sys_i)
        !rst_n_i |=> ctrl_ff == OSC_CTRL_RESET) // [R17]
        else $error("control register reset value wrong");

    c_unlock_write: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ctrl_update);
    c_recovery: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        pf_event && watchdog_osc_en_o);
    c_wdog_fail: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wf_event);
    c_irq: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        irq_o);
endmodule : clock_source_field_ctrl

// file: testbench/clock_source_field_osc_model.sv
// Far-side model: watchdog oscillator and primary clock failure source
`timescale 1ns/1ps
module clock_source_field_osc_model #(
    parameter int HALF_NS = 36
) (
    input wire logic run_i, // Watchdog oscillator running
    input wire logic fail_i, // Primary oscillator failed
    output logic wdog_clk_o, // Watchdog oscillator output
    output logic primary_fail_o // Primary failure level
);
    // Free-running phase; stands low while stopped so a dead oscillator shows no edges
    initial wdog_clk_o = 1'b0;
    always #(HALF_NS) wdog_clk_o = run_i ? ~wdog_clk_o : 1'b0;
    // Failure level follows the bench command
    assign primary_fail_o = fail_i;
endmodule : clock_source_field_osc_model

// file: testbench/oscillator_select_control_tb_top.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/1ps
module oscillator_select_control_tb_top;
    import clock_source_field_pkg::*;
    localparam int WD_LIMIT = 20;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic xtal_dis = 1'b0;
    logic [1:0] xtal_mode = 2'h0;
    logic wd_run = 1'b1;
    logic pfail_cmd = 1'b0;
    logic pfail, wdog_clk, prec_en, prec_slow, xtal_en, pin_own, filt_en, wd_en;
    logic pnmi, wnmi, irq;
    logic rd_d = 1'b0;
    logic [7:0] rdata;
    logic [1:0] xmode;
    logic [2:0] sel;
    logic [7:0] exp_q[$];
    integer seed = 32'h7E02;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;

    clock_source_field_osc_model osc (.run_i(wd_run), .fail_i(pfail_cmd), .wdog_clk_o(wdog_clk),
        .primary_fail_o(pfail));

    clock_source_field_ctrl #(.WDOG_FAIL_LIMIT(WD_LIMIT)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .xtal_dis_opt_i(xtal_dis),
        .xtal_mode_opt_i(xtal_mode), .primary_fail_i(pfail), .wdog_clk_i(wdog_clk),
        .prec_osc_en_o(prec_en), .prec_slow_o(prec_slow), .crystal_osc_en_o(xtal_en),
        .crystal_pin_own_o(pin_own), .crystal_mode_o(xmode),
        .crystal_filter_en_o(filt_en), .watchdog_osc_en_o(wd_en),
        .sysclk_source_select_o(sel), .primary_fail_nmi_o(pnmi),
        .watchdog_fail_nmi_o(wnmi), .irq_o(irq));

    // ========================================
    // Clock and shared tasks
    always #4 clk_sys_i = ~clk_sys_i;

    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task results;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // Strobes start two edges apart so no signal is set twice in a time step
    task wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys_i);
        rd <= 1'b0;
    endtask : rd_reg

    task ctrl_wr(input logic [7:0] d);
        wr_reg(OSC_CTRL_ADDR, UNLOCK_KEY1);
        wr_reg(OSC_CTRL_ADDR, UNLOCK_KEY2);
        wr_reg(OSC_CTRL_ADDR, d);
    endtask : ctrl_wr

    // Read data stands only in the cycle after the strobe, so compare at that edge
    always @(posedge clk_sys_i)
    begin
        rd_d <= rd;
        cyc <= cyc + 1;
        if (rd_d === 1'b1)
            chk("rdata", exp_q.pop_front(), rdata);
        if (cyc == 60000)
        begin
            failures++;
            results();
        end
    end

    // ========================================
    // Main sequence
    initial
    begin
        logic [7:0] d;
        logic [7:0] e;
        logic seen;
        int n;
        xtal_mode = 2'($random(seed));
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        seen = 1'b0;
        repeat (2)
        begin
            @(negedge clk_sys_i);
            seen = seen | xtal_en;
        end
        @(negedge clk_sys_i);
        chk("xtal_boot", 8'h01, {7'h0, seen});
        chk("xtal_after", 8'h00, {7'h0, xtal_en});
        chk("en_rst", 8'h06, {5'h0, prec_en, wd_en, filt_en});
        chk("sel_rst", 8'h00, {5'h0, sel});
        chk("xmode", {6'h0, xtal_mode}, {6'h0, xmode});
        rd_reg(OSC_CTRL_ADDR, OSC_CTRL_RESET);
        rd_reg(OSC_STATUS_ADDR, 8'h00);
        rd_reg(OSC_MASK_ADDR, 8'h00);
        wr_reg(OSC_OPTION_ADDR, 8'hFF);
        rd_reg(OSC_OPTION_ADDR, {5'h0, xtal_mode, xtal_dis});
        rd_reg(12'h123, 8'h00);
        $display("test reset done");
        // Locked writes, split keys, relock and broken sequences
        wr_reg(OSC_CTRL_ADDR, 8'h55);
        rd_reg(OSC_CTRL_ADDR, OSC_CTRL_RESET);
        wr_reg(OSC_CTRL_ADDR, UNLOCK_KEY1);
        rd_reg(OSC_MASK_ADDR, 8'h00);
        wr_reg(OSC_CTRL_ADDR, UNLOCK_KEY2);
        wr_reg(OSC_CTRL_ADDR, 8'h21);
        rd_reg(OSC_CTRL_ADDR, 8'h21);
        wr_reg(OSC_CTRL_ADDR, 8'hA0);
        rd_reg(OSC_CTRL_ADDR, 8'h21);
        wr_reg(OSC_CTRL_ADDR, UNLOCK_KEY1);
        wr_reg(OSC_CTRL_ADDR, UNLOCK_KEY1);
        wr_reg(OSC_CTRL_ADDR, UNLOCK_KEY2);
        wr_reg(OSC_CTRL_ADDR, 8'hA0);
        rd_reg(OSC_CTRL_ADDR, 8'h21);
        $display("test lock done");
        // Every select code, reserved ones keep the old source
        e = 8'h00;
        for (int c = 0; c < 8; c++)
        begin
            d = (8'($random(seed)) & 8'hE0) | 8'(c);
            e = (c < 5) ? d : {d[7:3], e[2:0]};
            ctrl_wr(d);
            rd_reg(OSC_CTRL_ADDR, e);
            @(negedge clk_sys_i);
            chk("sel", {5'h0, e[2:0]}, {5'h0, sel});
            chk("slow", {7'h0, e[2:0] == 3'h1}, {7'h0, prec_slow});
            chk("en", {5'h0, e[7:5]}, {5'h0, prec_en, xtal_en, wd_en});
            chk("pins", {7'h0, e[6]}, {7'h0, pin_own});
        end
        $display("test select done");
        // Crystal is given its settle time before it drives the system clock
        ctrl_wr(8'hE0);
        repeat (XTAL_SETTLE_SYS_CYCLES) @(posedge clk_sys_i);
        ctrl_wr(8'hE0 | {5'h0, SRC_CRYSTAL});
        @(negedge clk_sys_i);
        chk("sel_xtal", 8'h02, {5'h0, sel});
        $display("test crystal done");
        // Primary failure with recovery on, then with detection off
        ctrl_wr(8'hB0);
        wr_reg(OSC_MASK_ADDR, 8'h01);
        pfail_cmd <= 1'b1;
        n = 0;
        while (n < 20 && pnmi !== 1'b1)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        chk("pnmi", 8'h01, {7'h0, pnmi});
        repeat (3) @(negedge clk_sys_i);
        chk("sel_rec", 8'h03, {5'h0, sel});
        chk("irq_on", 8'h01, {7'h0, irq});
        rd_reg(OSC_STATUS_ADDR, 8'h05);
        rd_reg(OSC_CTRL_ADDR, 8'hB3);
        wr_reg(OSC_STATUS_ADDR, 8'h07);
        pfail_cmd <= 1'b0;
        @(negedge clk_sys_i);
        chk("irq_off", 8'h00, {7'h0, irq});
        ctrl_wr(8'hA0);
        pfail_cmd <= 1'b1;
        seen = 1'b0;
        repeat (10)
        begin
            @(negedge clk_sys_i);
            seen = seen | pnmi;
        end
        chk("pnmi_off", 8'h00, {7'h0, seen});
        rd_reg(OSC_CTRL_ADDR, 8'hA0);
        pfail_cmd <= 1'b0;
        $display("test primary done");
        // Watchdog oscillator failure, status bit left masked
        ctrl_wr(8'hA8);
        seen = 1'b0;
        repeat (60)
        begin
            @(negedge clk_sys_i);
            seen = seen | wnmi;
        end
        chk("wnmi_live", 8'h00, {7'h0, seen});
        @(posedge clk_sys_i);
        wd_run <= 1'b0;
        n = 0;
        while (n < 100 && wnmi !== 1'b1)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        chk("wd_cycles", 8'h01, {7'h0, n >= WD_LIMIT - 10 && n <= WD_LIMIT + 8});
        rd_reg(OSC_STATUS_ADDR, 8'h02);
        @(negedge clk_sys_i);
        chk("irq_mask", 8'h00, {7'h0, irq});
        $display("test watchdog done");
        // Second reset in mid-run with the crystal option strapped off
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        xtal_dis <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        seen = 1'b0;
        repeat (3)
        begin
            @(negedge clk_sys_i);
            seen = seen | xtal_en;
        end
        chk("xtal_dis", 8'h00, {7'h0, seen});
        chk("sel_rst2", 8'h00, {5'h0, sel});
        rd_reg(OSC_CTRL_ADDR, OSC_CTRL_RESET);
        rd_reg(OSC_OPTION_ADDR, {5'h0, xtal_mode, 1'b1});
        $display("test reset option done");
        results();
    end
endmodule : oscillator_select_control_tb_top
